// ### core/srq_pkg.sv
// Constants, register map and carrier types for the status/SRQ block.
// Assumes a single AHB-Lite slave window of 512 bytes, word accesses.
package srq_pkg;

   // Group geometry: user, device state, questionable, std event, oper
   localparam int NG = 5;
   localparam int GW = 16;
   localparam int AW = 9;

   // Per-group register index (byte address = group*0x20 + index*4)
   localparam logic [2:0] R_COND  = 3'h0;
   localparam logic [2:0] R_PTR   = 3'h1;
   localparam logic [2:0] R_NTR   = 3'h2;
   localparam logic [2:0] R_EV    = 3'h3;
   localparam logic [2:0] R_EN    = 3'h4;

   // System page (byte address 0x100 + index*4)
   localparam logic [2:0] R_STB   = 3'h0;
   localparam logic [2:0] R_SRE   = 3'h1;
   localparam logic [2:0] R_SPOLL = 3'h2;
   localparam logic [2:0] R_CMD   = 3'h3;

   // Command register bits
   localparam int CMD_CLS_BIT = 0;
   localparam int CMD_RST_BIT = 1;

   // Status byte layout
   localparam logic [2:0] SUM_POS [NG] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
   localparam int         MAV_POS = 4;
   localparam int         RQS_POS = 6;

   // Reset and default values
   localparam logic [GW-1:0] PTR_RST = 16'hffff;
   localparam logic [GW-1:0] NTR_RST = 16'h0000;
   localparam logic [GW-1:0] EN_RST  = 16'h0000;
   localparam logic [7:0]    SRE_RST = 8'h00;
   localparam logic [7:0]    SRE_MASK = 8'hbf;

   // Captured AHB address phase
   typedef struct packed {
      logic          valid;
      logic          write;
      logic [AW-1:0] addr;
   } ahb_req_t;

endpackage

// ### core/status_srq.sv
// Status reporting groups with service-request generation, AHB-Lite slave.
// Assumes condition and message-available inputs are asynchronous pins and
// that this is the only slave on its bus (zero wait states, always OKAY).
`timescale 1ns/1ns
module status_srq (
   input  wire logic                  CORE_CLK_I,  // 125 MHz clock
   input  wire logic                  SYS_RST_I,   // Sync reset, high
   input  wire logic                  HSEL_I,      // Slave select
   input  wire logic [31:0]           HADDR_I,     // Byte address
   input  wire logic [1:0]            HTRANS_I,    // Transfer type
   input  wire logic                  HWRITE_I,    // Write when high
   input  wire logic [2:0]            HSIZE_I,     // Word only
   input  wire logic [31:0]           HWDATA_I,    // Write data
   input  wire logic                  HREADY_I,    // Bus ready
   output logic      [31:0]           HRDATA_O,    // Read data
   output logic                       HREADYOUT_O, // Slave ready
   output logic                       HRESP_O,     // Always OKAY
   input  wire logic [srq_pkg::NG-1:0][srq_pkg::GW-1:0] COND_I, // Conditions
   input  wire logic                  MAV_I,       // Output msg available
   output logic                       SRQ_O,       // Service request line
   output logic                       MSS_O        // Master summary
);
   import srq_pkg::*;

   logic [NG-1:0][GW-1:0] cond_s1_r;
   logic [NG-1:0][GW-1:0] cond_r;
   logic [NG-1:0][GW-1:0] cond_old_r;
   logic [NG-1:0][GW-1:0] ptr_r;
   logic [NG-1:0][GW-1:0] ntr_r;
   logic [NG-1:0][GW-1:0] ev_r;
   logic [NG-1:0][GW-1:0] en_r;
   logic [NG-1:0][GW-1:0] chg;
   logic [NG-1:0]         rd_ev;
   logic [NG-1:0]         grp_sum;
   logic                  mav_s1_r;
   logic                  mav_r;
   logic [7:0]            stb;
   logic [7:0]            stb_old_r;
   logic [7:0]            sre_r;
   logic                  rqs_r;
   logic                  mss;
   logic                  srq_start;
   logic                  poll_rd;
   logic                  ap_rd;
   logic                  wr;
   logic                  cls;
   logic                  rstc;
   ahb_req_t              dp_r;
   logic [31:0]           rdata;
   logic [31:0]           hrdata_r;
   logic                  hready_r;

   // True when an address hits register idx of group g
   function automatic logic grp_hit(input logic [AW-1:0] a,
                                    input int g, input logic [2:0] idx);
      return !a[8] && (a[7:5] == 3'(g)) && (a[4:2] == idx);
   endfunction

   // True when an address hits register idx of the system page
   function automatic logic sys_hit(input logic [AW-1:0] a,
                                    input logic [2:0] idx);
      return a[8] && (a[7:5] == 3'h0) && (a[4:2] == idx);
   endfunction

   // Bus strobes: reads act in the address phase, writes in the data phase
   assign ap_rd   = HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
   assign wr      = dp_r.valid && dp_r.write;
   assign cls     = wr && sys_hit(dp_r.addr, R_CMD) && HWDATA_I[CMD_CLS_BIT];
   assign rstc    = wr && sys_hit(dp_r.addr, R_CMD) && HWDATA_I[CMD_RST_BIT];
   assign poll_rd = ap_rd && sys_hit(HADDR_I[AW-1:0], R_SPOLL);

   // Capture the address phase for the following data phase
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         dp_r <= '0;
      end else if (HREADY_I) begin
         dp_r.valid <= HSEL_I && HTRANS_I[1];
         dp_r.write <= HWRITE_I;
         dp_r.addr  <= HADDR_I[AW-1:0];
      end
   end

   // Two-flop synchronisers plus previous value for edge detection
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         cond_s1_r  <= '0;
         cond_r     <= '0;
         cond_old_r <= '0;
         mav_s1_r   <= 1'b0;
         mav_r      <= 1'b0;
      end else begin
         cond_s1_r  <= COND_I;
         cond_r     <= cond_s1_r;   // Live condition view
         cond_old_r <= cond_r;
         mav_s1_r   <= MAV_I;
         mav_r      <= mav_s1_r;
      end
   end

   // Per-group transition filter, read-clear strobe and summary
   for (genvar g = 0; g < NG; g++) begin : g_grp
      assign chg[g] = (cond_r[g] & ~cond_old_r[g] & ptr_r[g])
                    | (~cond_r[g] & cond_old_r[g] & ntr_r[g]);
      assign rd_ev[g] = ap_rd && grp_hit(HADDR_I[AW-1:0], g, R_EV);
      assign grp_sum[g] = |(ev_r[g] & en_r[g]);
   end

   // Transition filters: defaults on reset or reset command only
   always_ff @(posedge CORE_CLK_I) begin
      for (int g = 0; g < NG; g++) begin
         if (SYS_RST_I || rstc) begin
            ptr_r[g] <= PTR_RST;
            ntr_r[g] <= NTR_RST;
         end else begin
            if (wr && grp_hit(dp_r.addr, g, R_PTR))
               ptr_r[g] <= HWDATA_I[GW-1:0];
            if (wr && grp_hit(dp_r.addr, g, R_NTR))
               ntr_r[g] <= HWDATA_I[GW-1:0];
         end
      end
   end

   // Event latches: sticky, cleared by read or clear-status, set wins
   always_ff @(posedge CORE_CLK_I) begin
      for (int g = 0; g < NG; g++) begin
         if (SYS_RST_I)
            ev_r[g] <= '0;
         else if (cls || rd_ev[g])
            ev_r[g] <= chg[g];
         else
            ev_r[g] <= ev_r[g] | chg[g];
      end
   end

   // Enable masks: cleared by clear-status, untouched by reads
   always_ff @(posedge CORE_CLK_I) begin
      for (int g = 0; g < NG; g++) begin
         if (SYS_RST_I || cls)
            en_r[g] <= EN_RST;
         else if (wr && grp_hit(dp_r.addr, g, R_EN))
            en_r[g] <= HWDATA_I[GW-1:0];
      end
   end

   // Status byte assembly; bit 6 is filled in per view
   always_comb begin
      stb = 8'h00;
      for (int g = 0; g < NG; g++)
         stb[SUM_POS[g]] = grp_sum[g];
      stb[MAV_POS] = mav_r;
   end

   assign mss = |(stb & sre_r);

   // Service request enable, bit 6 forced low
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I)
         sre_r <= SRE_RST;
      else if (wr && sys_hit(dp_r.addr, R_SRE))
         sre_r <= HWDATA_I[7:0] & SRE_MASK;
   end

   // Request start: enabled summary rising while nothing pending
   assign srq_start = (|(stb & ~stb_old_r & sre_r)) && !rqs_r;

   // Request-service flag doubles as the SRQ line
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         stb_old_r <= 8'h00;
         rqs_r     <= 1'b0;
         MSS_O     <= 1'b0;
      end else begin
         stb_old_r <= stb;
         MSS_O     <= mss;
         if (srq_start)
            rqs_r <= 1'b1;
         else if (poll_rd)
            rqs_r <= 1'b0;
      end
   end

   assign SRQ_O = rqs_r;

   // Read mux, decoded in the address phase
   always_comb begin
      rdata = 32'h0000_0000;
      for (int g = 0; g < NG; g++) begin
         if (grp_hit(HADDR_I[AW-1:0], g, R_COND))
            rdata[GW-1:0] = cond_r[g];
         if (grp_hit(HADDR_I[AW-1:0], g, R_PTR))
            rdata[GW-1:0] = ptr_r[g];
         if (grp_hit(HADDR_I[AW-1:0], g, R_NTR))
            rdata[GW-1:0] = ntr_r[g];
         if (grp_hit(HADDR_I[AW-1:0], g, R_EV))
            rdata[GW-1:0] = ev_r[g];
         if (grp_hit(HADDR_I[AW-1:0], g, R_EN))
            rdata[GW-1:0] = en_r[g];
      end
      if (sys_hit(HADDR_I[AW-1:0], R_STB)) begin
         rdata[7:0]     = stb;
         rdata[RQS_POS] = mss;
      end
      if (sys_hit(HADDR_I[AW-1:0], R_SRE))
         rdata[7:0] = sre_r;
      if (sys_hit(HADDR_I[AW-1:0], R_SPOLL)) begin
         rdata[7:0]     = stb;
         rdata[RQS_POS] = rqs_r;
      end
   end

   // Bus answer: registered data, always ready, always OKAY
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         hrdata_r <= 32'h0000_0000;
         hready_r <= 1'b1;
         HRESP_O  <= 1'b0;
      end else begin
         hrdata_r <= ap_rd ? rdata : 32'h0000_0000;
         hready_r <= 1'b1;
         HRESP_O  <= 1'b0;
      end
   end

   assign HRDATA_O    = hrdata_r;
   assign HREADYOUT_O = hready_r;

   // Checks
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   a_rise_sets_event: assert property (
      (cond_r[0] & ~cond_old_r[0] & ptr_r[0]) != '0
      |=> ((ev_r[0] & $past(cond_r[0] & ~cond_old_r[0] & ptr_r[0]))
           == $past(cond_r[0] & ~cond_old_r[0] & ptr_r[0])))
      else $error("Rising condition not latched");

   a_fall_sets_event: assert property (
      ((~cond_r[0] & cond_old_r[0] & ntr_r[0]) != '0)
      |=> ((ev_r[0] & $past(~cond_r[0] & cond_old_r[0] & ntr_r[0]))
           == $past(~cond_r[0] & cond_old_r[0] & ntr_r[0])))
      else $error("Falling condition not latched");

   a_event_sticky_hold: assert property (
      !cls && !rd_ev[0] |=> ((ev_r[0] & $past(ev_r[0])) == $past(ev_r[0])))
      else $error("Event bit lost without clear");

   a_clear_status_events: assert property (
      cls |=> (en_r[0] == '0) && ((ev_r[0] & ~$past(chg[0])) == '0))
      else $error("Clear-status left events or enables");

   a_filters_survive_clear: assert property (
      cls && !rstc |=> $stable(ptr_r[0]) && $stable(ntr_r[0]))
      else $error("Filters changed by clear-status");

   a_summary_enabled_or: assert property (
      ap_rd && sys_hit(HADDR_I[AW-1:0], R_STB)
      |=> HRDATA_O[SUM_POS[0]] == $past(|(ev_r[0] & en_r[0])))
      else $error("Summary does not match enabled events");

   a_sre_bit_six: assert property (sre_r[RQS_POS] == 1'b0)
      else $error("Enable bit 6 not zero");

   a_srq_start_drive: assert property (
      srq_start |=> SRQ_O && MSS_O)
      else $error("Request did not raise SRQ");

   a_srq_pending_hold: assert property (
      SRQ_O && !poll_rd |=> SRQ_O)
      else $error("Pending request dropped without poll");

   a_poll_clears_rqs: assert property (
      poll_rd && !srq_start |=> !SRQ_O ##0 (HRDATA_O[RQS_POS] == $past(rqs_r)))
      else $error("Serial poll did not clear request");

   a_mss_follows_cause: assert property (
      ((stb & sre_r) == 8'h00) |=> !MSS_O)
      else $error("Master summary set without cause");

   c_srq_raised: cover property (srq_start);
   c_poll_after_srq: cover property (SRQ_O ##[1:20] poll_rd);
   c_event_read_clear: cover property ((ev_r[0] != '0) && rd_ev[0]);

endmodule

// ### tb/bus_ctrl.sv
// Bus controller model: AHB-Lite master doing register access and polls.
// Assumes the single slave's hreadyout is wired back as hready.
`timescale 1ns/1ns
module bus_ctrl (
   input  wire logic        clk_i,    // Bus clock
   input  wire logic        hready_i, // Bus ready
   input  wire logic [31:0] hrdata_i, // Read data
   output logic             hsel_o,   // Slave select
   output logic [31:0]      haddr_o,  // Byte address
   output logic [1:0]       htrans_o, // Transfer type
   output logic             hwrite_o, // Write flag
   output logic [31:0]      hwdata_o  // Write data
);
   import srq_pkg::*;

   // Idle bus at time zero
   initial begin
      hsel_o = 1'b0;
      haddr_o = '0;
      htrans_o = 2'b00;
      hwrite_o = 1'b0;
      hwdata_o = '0;
   end

   // One single word transfer; released lines show inverted values
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      hsel_o <= 1'b1;
      htrans_o <= 2'b10;
      haddr_o <= a;
      hwrite_o <= w;
      @(posedge clk_i);
      while (!hready_i) @(posedge clk_i);
      hsel_o <= 1'b0;
      htrans_o <= 2'b00;
      haddr_o <= ~a;
      hwdata_o <= w ? d : ~hwdata_o;
      @(posedge clk_i);
      while (!hready_i) @(posedge clk_i);
      q = hrdata_i;
      hwdata_o <= ~hwdata_o;
   endtask

   // Serial poll answering the service request line
   task automatic spoll(output logic [7:0] sb);
      logic [31:0] q;
      xfer(1'b0, 32'h100 + 32'(R_SPOLL) * 4, 32'h0, q);
      sb = q[7:0];
   endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the status groups and service request logic.
// Assumes the bus controller model drives the slave port alone.
`timescale 1ns/1ns
module tb_top;
   import srq_pkg::*;
   typedef struct {int g; int b; bit p; bit n; bit rise; bit ev;} row_t;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic [NG-1:0][GW-1:0] cond = '0;
   logic                  mav = 1'b0;
   logic                  hsel, hwrite, hready, srq, mss, hresp;
   logic [1:0]            htrans;
   logic [31:0]           haddr, hwdata, hrdata, q, m;
   logic [7:0]            sb;
   int                    fails = 0;
   int                    checks = 0;
   row_t                  r;
   row_t rows [6] = '{'{0, 0, 1, 0, 1, 1}, '{1, 3, 0, 0, 1, 0},
                      '{2, 15, 0, 1, 0, 1}, '{3, 7, 1, 0, 0, 0},
                      '{4, 1, 1, 1, 1, 1}, '{4, 1, 1, 1, 0, 1}};

   // 125 MHz clock
   always #4 clk = ~clk;

   status_srq u_dut (
      .CORE_CLK_I (clk),
      .SYS_RST_I  (rst),
      .HSEL_I     (hsel),
      .HADDR_I    (haddr),
      .HTRANS_I   (htrans),
      .HWRITE_I   (hwrite),
      .HSIZE_I    (3'h2),
      .HWDATA_I   (hwdata),
      .HREADY_I   (hready),
      .HRDATA_O   (hrdata),
      .HREADYOUT_O(hready),
      .HRESP_O    (hresp),
      .COND_I     (cond),
      .MAV_I      (mav),
      .SRQ_O      (srq),
      .MSS_O      (mss)
   );

   bus_ctrl u_bus (
      .clk_i   (clk),
      .hready_i(hready),
      .hrdata_i(hrdata),
      .hsel_o  (hsel),
      .haddr_o (haddr),
      .htrans_o(htrans),
      .hwrite_o(hwrite),
      .hwdata_o(hwdata)
   );

   // Address helpers
   function automatic logic [31:0] ga(input int g, input logic [2:0] i);
      return 32'(g * 32) + 32'(i) * 4;
   endfunction
   function automatic logic [31:0] sa(input logic [2:0] i);
      return 32'h100 + 32'(i) * 4;
   endfunction

   task automatic rd(input logic [31:0] a);
      u_bus.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      u_bus.xfer(1'b1, a, d, x);
   endtask

   // Compare a register word
   task automatic chkw(input string s, input logic [31:0] e,
                       input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("FAIL %s expected %h seen %h", s, e, g);
      end
   endtask
   // Compare a flag
   task automatic chkb(input string s, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("FAIL %s expected %b seen %b", s, e, g);
      end
   endtask

   task automatic setc(input int g, input int b, input logic v);
      @(posedge clk);
      cond[g][b] <= v;
      repeat (6) @(posedge clk);
   endtask

   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test();
   end

   // Main sequence; filters are set before each checked condition edge
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(ga(4, R_PTR));
      chkw("ptr rst", {16'h0, PTR_RST}, q);
      rd(sa(R_SRE));
      chkw("sre rst", 32'h0, q);
      chkb("srq rst", 1'b0, srq);
      chkb("mss rst", 1'b0, mss);
      chkb("hready", 1'b1, hready);
      chkb("hresp", 1'b0, hresp);
      $display("test reset done");
      foreach (rows[i]) begin
         r = rows[i];
         m = 32'h1 << r.b;
         setc(r.g, r.b, !r.rise);
         wr(ga(r.g, R_PTR), r.p ? m : 32'h0);
         wr(ga(r.g, R_NTR), r.n ? m : 32'h0);
         rd(ga(r.g, R_EV));
         setc(r.g, r.b, r.rise);
         rd(ga(r.g, R_COND));
         chkw("cond", r.rise ? m : 32'h0, q & m);
         rd(ga(r.g, R_EV));
         chkw("event", r.ev ? m : 32'h0, q);
         rd(ga(r.g, R_EV));
         chkw("event clr", 32'h0, q);
         $display("test row %0d done", i);
      end
      wr(ga(3, R_PTR), 32'h4);
      wr(ga(3, R_EN), 32'h4);
      wr(sa(R_SRE), 32'h30);
      setc(3, 2, 1'b1);
      chkb("srq", 1'b1, srq);
      chkb("mss", 1'b1, mss);
      @(posedge clk);
      mav <= 1'b1;
      repeat (4) @(posedge clk);
      u_bus.spoll(sb);
      chkw("poll", 32'h70, {24'h0, sb});
      repeat (3) @(posedge clk);
      chkb("srq off", 1'b0, srq);
      rd(sa(R_STB));
      chkw("stb", 32'h70, q);
      rd(ga(3, R_EV));
      repeat (4) @(posedge clk);
      rd(sa(R_STB));
      chkw("stb mav", 32'h50, q);
      chkb("srq held", 1'b0, srq);
      @(posedge clk);
      mav <= 1'b0;
      setc(3, 2, 1'b0);
      chkb("mss off", 1'b0, mss);
      setc(3, 2, 1'b1);
      chkb("srq again", 1'b1, srq);
      wr(ga(3, R_EN), 32'h0);
      rd(sa(R_STB));
      chkw("stb masked", 32'h0, q);
      u_bus.spoll(sb);
      chkw("poll rqs", 32'h40, {24'h0, sb});
      $display("test request done");
      wr(sa(R_SRE), 32'hff);
      rd(sa(R_SRE));
      chkw("sre mask", {24'h0, SRE_MASK}, q);
      wr(ga(2, R_EN), 32'h1234);
      rd(ga(2, R_EN));
      rd(ga(2, R_EN));
      chkw("en", 32'h1234, q);
      wr(sa(R_CMD), 32'h1);
      rd(ga(2, R_EN));
      chkw("en cls", 32'h0, q);
      rd(ga(2, R_NTR));
      chkw("ntr cls", 32'h8000, q);
      wr(sa(R_CMD), 32'h2);
      rd(ga(2, R_NTR));
      chkw("ntr def", {16'h0, NTR_RST}, q);
      rd(32'h1f0);
      chkw("unmapped", 32'h0, q);
      $display("test commands done");
      // Reset again in mid-run: filters and service request enable back to defaults
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(sa(R_SRE));
      chkw("sre rst2", {24'h0, SRE_RST}, q);
      rd(ga(2, R_PTR));
      chkw("ptr rst2", {16'h0, PTR_RST}, q);
      chkb("srq rst2", 1'b0, srq);
      $display("test second reset done");
      end_of_test();
   end
endmodule
